// ### logic/sor_check.sv
// Range and rating check of a register write
module sor_check (
	// Write being checked
	input  wire logic [sor_pkg::AW-1:0] addr,
	input  wire logic [sor_pkg::DW-1:0] wdata,
	// Stored rating settings
	input  wire logic [6:0]             rated,
	input  wire logic [7:0]             sf,
	// Verdict
	output logic                        ok,
	output logic                        mapped
);
	import sor_pkg::*;

	logic [15:0] prod_r;
	logic [15:0] prod_s;

	// Rated current times margin factor, each side against the stored other
	assign prod_r = 16'(wdata[6:0]) * 16'(sf);
	assign prod_s = 16'(rated) * 16'(wdata[7:0]);

	// Accept only values inside each documented range
	always_comb begin
		ok = 1'b1;
		mapped = 1'b1;
		unique case (addr)
			OFS_RATED: ok = wdata >= 32'(RATED_MIN) && wdata <= 32'(RATED_MAX)
				&& prod_r <= PROD_LIMIT;
			OFS_SF: ok = wdata >= 32'(SF_MIN) && wdata <= 32'(SF_MAX)
				&& prod_s <= PROD_LIMIT;
			OFS_CST: ok = wdata >= 32'(CST_MIN) && wdata <= 32'(CST_MAX);
			OFS_CRUN: ok = wdata >= 32'(CRUN_MIN) && wdata <= 32'(CRUN_MAX);
			OFS_POL: ok = wdata <= 32'(POL_OFF);
			OFS_PAIR: ok = wdata >= 32'(PAIR_VV) && wdata <= 32'(PAIR_CV);
			OFS_IVOLT: ok = wdata <= 32'(IVOLT_MAX);
			OFS_ICUR: ok = wdata <= 32'(ICUR_MAX);
			OFS_ATIME: ok = wdata >= 32'(ATIME_MIN) && wdata <= 32'(ATIME_MAX);
			OFS_CEIL: ok = wdata >= 32'(CEIL_MIN) && wdata <= 32'(CEIL_MAX);
			OFS_STAT, OFS_ISTS, OFS_IMASK: ok = 1'b1;
			default: begin
				ok = 1'b0;
				mapped = 1'b0;
			end
		endcase
	end

endmodule

// ### logic/sor_pkg.sv
// Constants, register map and state codes of the starter setup block
package sor_pkg;

	// ************************************************
	// Bus geometry
	// ************************************************
	localparam int AW = 6;
	localparam int DW = 32;

	// ************************************************
	// Register byte offsets
	// ************************************************
	localparam logic [5:0] OFS_RATED = 6'h00;
	localparam logic [5:0] OFS_SF    = 6'h04;
	localparam logic [5:0] OFS_CST   = 6'h08;
	localparam logic [5:0] OFS_CRUN  = 6'h0C;
	localparam logic [5:0] OFS_POL   = 6'h10;
	localparam logic [5:0] OFS_PAIR  = 6'h14;
	localparam logic [5:0] OFS_IVOLT = 6'h18;
	localparam logic [5:0] OFS_ICUR  = 6'h1C;
	localparam logic [5:0] OFS_ATIME = 6'h20;
	localparam logic [5:0] OFS_CEIL  = 6'h24;
	localparam logic [5:0] OFS_STAT  = 6'h28;
	localparam logic [5:0] OFS_ISTS  = 6'h2C;
	localparam logic [5:0] OFS_IMASK = 6'h30;

	// ************************************************
	// Setting ranges and reset values
	// ************************************************
	localparam logic [6:0] RATED_MIN = 7'h32;
	localparam logic [6:0] RATED_MAX = 7'h64;
	localparam logic [6:0] RATED_DEF = 7'h00;
	localparam logic [7:0] SF_MIN    = 8'h64;
	localparam logic [7:0] SF_MAX    = 8'h82;
	localparam logic [7:0] SF_DEF    = 8'h64;
	localparam logic [15:0] PROD_LIMIT = 16'h2710;
	localparam logic [4:0] CST_MIN   = 5'h05;
	localparam logic [4:0] CST_MAX   = 5'h14;
	localparam logic [4:0] CRUN_MIN  = 5'h05;
	localparam logic [4:0] CRUN_MAX  = 5'h1E;
	localparam logic [4:0] CLASS_DEF = 5'h0A;
	localparam logic [1:0] POL_MANUAL = 2'h0;
	localparam logic [1:0] POL_AUTO   = 2'h1;
	localparam logic [1:0] POL_OFF    = 2'h2;
	localparam logic [2:0] PAIR_VV   = 3'h1;
	localparam logic [2:0] PAIR_CC   = 3'h2;
	localparam logic [2:0] PAIR_VC   = 3'h3;
	localparam logic [2:0] PAIR_CV   = 3'h4;
	localparam logic [6:0] IVOLT_MAX = 7'h64;
	localparam logic [6:0] IVOLT_DEF = 7'h3C;
	localparam logic [9:0] ICUR_MAX  = 10'h258;
	localparam logic [9:0] ICUR_DEF  = 10'h0C8;
	localparam logic [6:0] ATIME_MIN = 7'h01;
	localparam logic [6:0] ATIME_MAX = 7'h78;
	localparam logic [6:0] ATIME_DEF = 7'h0A;
	localparam logic [9:0] CEIL_MIN  = 10'h0C8;
	localparam logic [9:0] CEIL_MAX  = 10'h258;
	localparam logic [9:0] CEIL_DEF  = 10'h15E;

	// ************************************************
	// Status and interrupt bit positions
	// ************************************************
	localparam int ST_CFG   = 0;
	localparam int ST_TRIP  = 1;
	localparam int ST_R2    = 2;
	localparam int ST_CUR   = 3;
	localparam int ST_FSM   = 4;
	localparam int IRQ_W    = 3;
	localparam int IRQ_REJ  = 0;
	localparam int IRQ_TRIP = 1;
	localparam int IRQ_CLR  = 2;

	// ************************************************
	// Motor sequence states
	// ************************************************
	typedef enum logic [2:0] {
		SOR_BOOT  = 3'h0,
		SOR_STOP  = 3'h1,
		SOR_ACCEL = 3'h2,
		SOR_FULL  = 3'h3,
		SOR_TRIP  = 3'h4
	} sor_state_t;

endpackage

// ### logic/sor_top.sv
// Soft starter setting store, overload recovery and ramp selection
module sor_top (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Avalon-MM slave
	input  wire logic [sor_pkg::AW-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [sor_pkg::DW-1:0] avs_writedata,
	output logic      [sor_pkg::DW-1:0] avs_readdata,
	output logic                        avs_waitrequest,
	output logic                        irq,
	// Operator and motor inputs
	input  wire logic                   start_cmd,
	input  wire logic                   stop_cmd,
	input  wire logic                   two_wire,
	input  wire logic                   reset_key,
	input  wire logic                   dual_ramp_closed,
	input  wire logic                   full_speed,
	input  wire logic                   thermal_trip,
	input  wire logic                   windings_cooled,
	// Retained state across control power loss
	input  wire logic                   retained_trip,
	input  wire logic [1:0]             retained_policy,
	input  wire logic                   thermal_capacity_ok,
	// Motor control outputs
	output logic                        motor_run,
	output logic                        trip_latched,
	output logic      [4:0]             active_trip_class,
	// Ramp selection and ramp one outputs
	output logic                        ramp_two_sel,
	output logic                        ramp_current_type,
	output logic      [6:0]             ramp_init_voltage,
	output logic      [16:0]            ramp_init_current,
	output logic      [6:0]             ramp_accel_time,
	output logic      [16:0]            ramp_current_ceiling
);
	import sor_pkg::*;

	// ************************************************
	// State
	// ************************************************
	typedef struct packed {
		sor_state_t  state;
		logic        wait_n;
		logic [31:0] rdata;
		logic [6:0]  rated;
		logic [7:0]  sf;
		logic [4:0]  cst;
		logic [4:0]  crun;
		logic [1:0]  pol;
		logic [2:0]  pair;
		logic [6:0]  ivolt;
		logic [9:0]  icur;
		logic [6:0]  atime;
		logic [9:0]  ceil;
		logic [IRQ_W-1:0] ists;
		logic [IRQ_W-1:0] imask;
		logic        irq;
		logic        wreq;
		logic        trip;
		logic        start_q;
		logic        run;
		logic [4:0]  cls;
		logic        r2;
		logic        rcur;
		logic [6:0]  o_volt;
		logic [16:0] o_icur;
		logic [6:0]  o_time;
		logic [16:0] o_ceil;
	} sor_regs_t;

	localparam sor_regs_t RST = '{
		state: SOR_BOOT, wait_n: 1'b0, rdata: '0,
		rated: RATED_DEF, sf: SF_DEF, cst: CLASS_DEF, crun: CLASS_DEF,
		pol: POL_MANUAL, pair: PAIR_VV, ivolt: IVOLT_DEF, icur: ICUR_DEF,
		atime: ATIME_DEF, ceil: CEIL_DEF, ists: '0, imask: '0,
		irq: 1'b0, wreq: 1'b1, trip: 1'b0, start_q: 1'b0, run: 1'b0, cls: '0, r2: 1'b0,
		rcur: 1'b0, o_volt: '0, o_icur: '0, o_time: '0, o_ceil: '0
	};

	sor_regs_t st;
	sor_regs_t next_st;

	logic wr_ok;
	logic wr_mapped;
	logic wr_do;
	logic go;
	logic stopping;
	logic trip_now;
	logic r1cur;
	logic r2cur;
	logic [IRQ_W-1:0] set_ev;
	logic [IRQ_W-1:0] clr_ev;
	logic [31:0] rd;

	// ************************************************
	// Write check
	// ************************************************
	sor_check sor_check_i (
		.addr   (avs_address),
		.wdata  (avs_writedata),
		.rated  (st.rated),
		.sf     (st.sf),
		.ok     (wr_ok),
		.mapped (wr_mapped)
	);

	// Write takes effect on the edge that ends the answer cycle
	assign wr_do = avs_write && st.wait_n;

	// Start request: level for two-wire, rising edge otherwise
	assign go = two_wire ? start_cmd : (start_cmd && !st.start_q);
	assign stopping = stop_cmd || (two_wire && !start_cmd);
	assign trip_now = thermal_trip && st.pol != POL_OFF;

	// Ramp types of each profile pair
	assign r1cur = st.pair == PAIR_CC || st.pair == PAIR_CV;
	assign r2cur = st.pair == PAIR_CC || st.pair == PAIR_VC;

	// ************************************************
	// Read multiplexer
	// ************************************************
	always_comb begin
		rd = '0;
		unique case (avs_address)
			OFS_RATED: rd = 32'(st.rated);
			OFS_SF:    rd = 32'(st.sf);
			OFS_CST:   rd = 32'(st.cst);
			OFS_CRUN:  rd = 32'(st.crun);
			OFS_POL:   rd = 32'(st.pol);
			OFS_PAIR:  rd = 32'(st.pair);
			OFS_IVOLT: rd = 32'(st.ivolt);
			OFS_ICUR:  rd = 32'(st.icur);
			OFS_ATIME: rd = 32'(st.atime);
			OFS_CEIL:  rd = 32'(st.ceil);
			OFS_STAT: begin
				rd[ST_CFG] = st.rated != RATED_DEF;
				rd[ST_TRIP] = st.state == SOR_TRIP;
				rd[ST_R2] = st.r2;
				rd[ST_CUR] = st.rcur;
				rd[ST_FSM +: 3] = st.state;
			end
			OFS_ISTS:  rd = 32'(st.ists);
			OFS_IMASK: rd = 32'(st.imask);
			default:   rd = '0;
		endcase
	end

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		next_st = st;
		set_ev = '0;
		clr_ev = '0;
		next_st.start_q = start_cmd;

		// Bus handshake: one wait cycle, then answer
		next_st.wait_n = 1'b0;
		if ((avs_read || avs_write) && !st.wait_n) begin
			next_st.wait_n = 1'b1;
			next_st.rdata = avs_read ? rd : '0;
		end
		next_st.wreq = !next_st.wait_n;

		// Register writes; refused values keep the old one
		if (wr_do && wr_mapped) begin
			if (!wr_ok) begin
				set_ev[IRQ_REJ] = 1'b1;
			end else begin
				unique case (avs_address)
					OFS_RATED: next_st.rated = avs_writedata[6:0];
					OFS_SF:    next_st.sf = avs_writedata[7:0];
					OFS_CST:   next_st.cst = avs_writedata[4:0];
					OFS_CRUN:  next_st.crun = avs_writedata[4:0];
					OFS_POL:   next_st.pol = avs_writedata[1:0];
					OFS_PAIR:  next_st.pair = avs_writedata[2:0];
					OFS_IVOLT: next_st.ivolt = avs_writedata[6:0];
					OFS_ICUR:  next_st.icur = avs_writedata[9:0];
					OFS_ATIME: next_st.atime = avs_writedata[6:0];
					OFS_CEIL:  next_st.ceil = avs_writedata[9:0];
					OFS_ISTS:  clr_ev = avs_writedata[IRQ_W-1:0];
					OFS_IMASK: next_st.imask = avs_writedata[IRQ_W-1:0];
					default:   next_st.rdata = st.rdata;
				endcase
			end
		end

		// Motor sequence and overload recovery
		unique case (st.state)
			SOR_BOOT: begin
				// Power cycle keeps a trip unless auto and cooled
				if (retained_policy <= POL_OFF) begin
					next_st.pol = retained_policy;
				end
				if (retained_trip && !(retained_policy == POL_AUTO
						&& thermal_capacity_ok)) begin
					next_st.state = SOR_TRIP;
				end else begin
					next_st.state = SOR_STOP;
				end
			end
			SOR_STOP: begin
				if (go && st.rated != RATED_DEF) begin
					next_st.state = SOR_ACCEL;
				end
			end
			SOR_ACCEL: begin
				if (stopping) begin
					next_st.state = SOR_STOP;
				end else if (trip_now) begin
					next_st.state = SOR_TRIP;
					set_ev[IRQ_TRIP] = 1'b1;
				end else if (full_speed) begin
					next_st.state = SOR_FULL;
				end
			end
			SOR_FULL: begin
				if (stopping) begin
					next_st.state = SOR_STOP;
				end else if (trip_now) begin
					next_st.state = SOR_TRIP;
					set_ev[IRQ_TRIP] = 1'b1;
				end
			end
			SOR_TRIP: begin
				// Manual needs the key once cooled; auto needs only cooling
				if (windings_cooled && (st.pol == POL_AUTO || reset_key)) begin
					next_st.state = SOR_STOP;
					set_ev[IRQ_CLR] = 1'b1;
				end
			end
			default: next_st.state = SOR_TRIP;
		endcase

		// Sticky events, set wins over write-one-to-clear
		next_st.ists = (st.ists & ~clr_ev) | set_ev;
		next_st.irq = |(next_st.ists & next_st.imask);

		// Motor outputs follow the next sequence state
		next_st.run = next_st.state == SOR_ACCEL || next_st.state == SOR_FULL;
		next_st.trip = next_st.state == SOR_TRIP;
		unique case (next_st.state)
			SOR_ACCEL: next_st.cls = next_st.cst;
			SOR_FULL:  next_st.cls = next_st.crun;
			default:   next_st.cls = '0;
		endcase

		// Ramp selection and ramp one parameters
		next_st.r2 = dual_ramp_closed;
		next_st.rcur = dual_ramp_closed ? r2cur : r1cur;
		next_st.o_volt = '0;
		next_st.o_icur = '0;
		next_st.o_time = '0;
		next_st.o_ceil = '0;
		if (!dual_ramp_closed) begin
			if (r1cur) begin
				next_st.o_icur = 17'(st.icur) * 17'(st.rated);
			end else begin
				next_st.o_volt = st.ivolt;
			end
			next_st.o_time = st.atime;
			next_st.o_ceil = 17'(st.ceil) * 17'(st.rated);
		end
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= RST;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.wreq;
	assign irq = st.irq;
	assign motor_run = st.run;
	assign trip_latched = st.trip;
	assign active_trip_class = st.cls;
	assign ramp_two_sel = st.r2;
	assign ramp_current_type = st.rcur;
	assign ramp_init_voltage = st.o_volt;
	assign ramp_init_current = st.o_icur;
	assign ramp_accel_time = st.o_time;
	assign ramp_current_ceiling = st.o_ceil;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	logic [15:0] chk_prod;
	assign chk_prod = 16'(st.rated) * 16'(st.sf);

	chk_no_run_unset: assert property (st.rated == RATED_DEF |-> !motor_run)
		else $error("motor runs without rated current");
	chk_prod_limit: assert property (chk_prod <= PROD_LIMIT)
		else $error("rated current times margin over maximum");
	chk_sf_range: assert property (st.sf >= SF_MIN && st.sf <= SF_MAX)
		else $error("margin factor out of range");
	chk_start_class: assert property (st.state == SOR_ACCEL |-> active_trip_class == st.cst)
		else $error("start class not presented");
	chk_run_class: assert property (st.state == SOR_FULL |-> active_trip_class == st.crun
		&& st.crun >= CRUN_MIN && st.crun <= CRUN_MAX)
		else $error("run class not presented at full speed");
	chk_manual_key: assert property (st.state == SOR_TRIP && st.pol != POL_AUTO
		&& next_st.state == SOR_STOP |-> reset_key && windings_cooled)
		else $error("manual recovery without key and cooling");
	chk_auto_clear: assert property (st.state == SOR_TRIP && st.pol == POL_AUTO
		&& windings_cooled |=> st.state == SOR_STOP ##1 !trip_latched)
		else $error("automatic recovery did not clear");
	chk_no_trip_off: assert property (st.pol == POL_OFF && motor_run
		|=> !trip_latched)
		else $error("trip while overload disabled");
	chk_ramp_sel: assert property (##1 ramp_two_sel == $past(dual_ramp_closed))
		else $error("ramp select does not follow input");
	chk_ramp_two_idle: assert property (ramp_two_sel |-> ramp_init_voltage == '0
		&& ramp_init_current == '0 && ramp_current_ceiling == '0)
		else $error("ramp one values while ramp two in use");
	chk_type_ignore: assert property (ramp_current_type |-> ramp_init_voltage == '0)
		else $error("voltage start used on current ramp");
	chk_volt_ignore: assert property (!ramp_current_type |-> ramp_init_current == '0)
		else $error("current start used on voltage ramp");
	chk_write_keep: assert property (wr_do && wr_mapped && !wr_ok
		|=> $stable(st.rated) && $stable(st.sf) && $stable(st.pair)
		&& st.ists[IRQ_REJ])
		else $error("refused write changed a setting");

	cov_start_full: cover property (st.state == SOR_ACCEL ##1 st.state == SOR_FULL);
	cov_trip_auto: cover property (st.state == SOR_TRIP && st.pol == POL_AUTO ##1 st.state == SOR_STOP);
	cov_reject: cover property (wr_do && !wr_ok && wr_mapped);
	cov_ramp_two: cover property (ramp_two_sel && ramp_current_type);

endmodule

// ### tb/sor_motor.sv
// Motor and thermal model partner of the starter setup block
module sor_motor #(
	parameter int ACCEL = 5,
	parameter int COOL  = 6
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Starter drive and bench heating command
	input  wire logic motor_run,
	input  wire logic heat,
	// Motor and thermal feedback
	output logic      full_speed,
	output logic      thermal_trip,
	output logic      windings_cooled
);
	timeunit 1ns;
	timeprecision 1ns;
	int acc;
	int cool;
	// Shaft speeds up while driven, windings cool only while stopped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc <= 0;
			cool <= 0;
		end else begin
			acc <= motor_run ? (acc < ACCEL ? acc + 1 : acc) : 0;
			cool <= motor_run ? 0 : (cool < COOL ? cool + 1 : cool);
		end
	end
	// Curve exceeded only while heated and driven, so a real trip removes it
	assign full_speed      = motor_run && acc >= ACCEL;
	assign thermal_trip    = heat && motor_run;
	assign windings_cooled = !motor_run && cool >= COOL;
endmodule

// ### tb/sor_top_tb.sv
// Self-checking bench of the starter setup block
module sor_top_tb;
	import sor_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, nrst, avs_read, avs_write, avs_waitrequest, irq, c;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, v;
	logic        start_cmd, stop_cmd, two_wire, reset_key, dual_ramp_closed, heat;
	logic        full_speed, thermal_trip, windings_cooled;
	logic        retained_trip, thermal_capacity_ok, motor_run, trip_latched;
	logic [1:0]  retained_policy;
	logic [4:0]  active_trip_class;
	logic        ramp_two_sel, ramp_current_type;
	logic [6:0]  ramp_init_voltage, ramp_accel_time;
	logic [16:0] ramp_init_current, ramp_current_ceiling;
	int          n_fail, checked, cyc;

	sor_top sor_top_i (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .irq, .start_cmd, .stop_cmd, .two_wire, .reset_key, .dual_ramp_closed,
		.full_speed, .thermal_trip, .windings_cooled, .retained_trip, .retained_policy,
		.thermal_capacity_ok, .motor_run, .trip_latched, .active_trip_class, .ramp_two_sel,
		.ramp_current_type, .ramp_init_voltage, .ramp_init_current, .ramp_accel_time, .ramp_current_ceiling);
	sor_motor sor_motor_i (.clk, .nrst, .motor_run, .heat, .full_speed, .thermal_trip, .windings_cooled);

	// ************************************************
	// Clock, timeout and tasks
	// ************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, v);
	endtask
	task automatic wrc(input string nm, input logic [5:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rdc(nm, a, e);
	endtask
	// Three-wire start on a rising edge, then settle
	task automatic go();
		start_cmd <= 1'b1;
		tick(2);
		start_cmd <= 1'b0;
		tick(2);
	endtask
	task automatic halt();
		stop_cmd <= 1'b1;
		tick(2);
		stop_cmd <= 1'b0;
		tick(2);
	endtask
	task automatic reboot(input logic t, input logic [1:0] p, input logic ok);
		retained_trip <= t;
		retained_policy <= p;
		thermal_capacity_ok <= ok;
		nrst <= 1'b0;
		tick(4);
		nrst <= 1'b1;
		tick(4);
	endtask

	// ************************************************
	// Test sequence
	// ************************************************
	initial begin
		{nrst, avs_read, avs_write, start_cmd, stop_cmd, two_wire, reset_key, heat} = '0;
		{dual_ramp_closed, retained_trip, thermal_capacity_ok, retained_policy} = '0;
		avs_address = '0;
		avs_writedata = '0;
		tick(4);
		nrst <= 1'b1;
		tick(1);
		rdc("rated", OFS_RATED, 32'h0);
		rdc("sf", OFS_SF, 32'h64);
		rdc("cst", OFS_CST, 32'h0A);
		rdc("pol", OFS_POL, 32'h0);
		rdc("pair", OFS_PAIR, 32'h1);
		rdc("ivolt", OFS_IVOLT, 32'h3C);
		rdc("icur", OFS_ICUR, 32'hC8);
		rdc("unmapped", 6'h3C, 32'h0);
		go();
		chk("run unrated", 32'h0, motor_run);
		$display("test defaults done");
		wrc("rated", OFS_RATED, 32'h31, 32'h0);
		wrc("rated", OFS_RATED, 32'h65, 32'h0);
		chk("irq masked", 32'h0, irq);
		rdc("ists", OFS_ISTS, 32'h1);
		wr(OFS_ISTS, 32'h1);
		wrc("rated", OFS_RATED, 32'h1000032, 32'h0);
		wrc("rated", OFS_RATED, 32'h32, 32'h32);
		wrc("sf", OFS_SF, 32'h63, 32'h64);
		wrc("sf", OFS_SF, 32'h83, 32'h64);
		wrc("cst", OFS_CST, 32'h4, 32'h0A);
		wrc("cst", OFS_CST, 32'h15, 32'h0A);
		wrc("cst", OFS_CST, 32'h0F, 32'h0F);
		wrc("crun", OFS_CRUN, 32'h1F, 32'h0A);
		wrc("crun", OFS_CRUN, 32'h1E, 32'h1E);
		wrc("pol", OFS_POL, 32'h3, 32'h0);
		wrc("pair", OFS_PAIR, 32'h0, 32'h1);
		wrc("pair", OFS_PAIR, 32'h5, 32'h1);
		wrc("ivolt", OFS_IVOLT, 32'h65, 32'h3C);
		wrc("ivolt", OFS_IVOLT, 32'h64, 32'h64);
		wrc("icur", OFS_ICUR, 32'h259, 32'hC8);
		wrc("icur", OFS_ICUR, 32'h258, 32'h258);
		wrc("atime", OFS_ATIME, 32'h79, 32'h0A);
		wrc("ceil", OFS_CEIL, 32'hC7, 32'h15E);
		wrc("rated", OFS_RATED, 32'h64, 32'h64);
		wrc("sf", OFS_SF, 32'h65, 32'h64);
		wrc("rated", OFS_RATED, 32'h4C, 32'h4C);
		wrc("sf", OFS_SF, 32'h82, 32'h82);
		wrc("rated", OFS_RATED, 32'h4D, 32'h4C);
		$display("test ranges done");
		// Rated 76 percent of unit maximum until the power cycle test
		for (int p = 1; p <= 4; p++) begin
			wr(OFS_PAIR, 32'(p));
			for (int d = 0; d < 2; d++) begin
				dual_ramp_closed <= d[0];
				tick(3);
				c = d ? (p == 2 || p == 3) : (p == 2 || p == 4);
				chk("ctype", c, ramp_current_type);
				chk("sel", d, ramp_two_sel);
				chk("ivolt", (d || c) ? 0 : 100, ramp_init_voltage);
				chk("icur", (d || !c) ? 0 : 600 * 76, ramp_init_current);
				chk("ceil", d ? 0 : 350 * 76, ramp_current_ceiling);
				chk("time", d ? 0 : 10, ramp_accel_time);
			end
		end
		dual_ramp_closed <= 1'b0;
		$display("test ramps done");
		wr(OFS_IMASK, 32'h2);
		go();
		chk("run", 32'h1, motor_run);
		chk("start class", 32'h0F, active_trip_class);
		tick(6);
		chk("run class", 32'h1E, active_trip_class);
		heat <= 1'b1;
		tick(3);
		heat <= 1'b0;
		chk("trip", 32'h1, trip_latched);
		chk("irq", 32'h1, irq);
		tick(10);
		go();
		chk("trip kept", 32'h1, trip_latched);
		reset_key <= 1'b1;
		tick(2);
		reset_key <= 1'b0;
		tick(2);
		chk("trip cleared", 32'h0, trip_latched);
		rdc("ists", OFS_ISTS, 32'h7);
		wr(OFS_ISTS, 32'h7);
		tick(2);
		chk("irq cleared", 32'h0, irq);
		go();
		chk("restart", 32'h1, motor_run);
		halt();
		chk("stopped", 32'h0, motor_run);
		$display("test manual done");
		wr(OFS_POL, 32'h1);
		two_wire <= 1'b1;
		start_cmd <= 1'b1;
		tick(3);
		heat <= 1'b1;
		tick(3);
		heat <= 1'b0;
		chk("auto trip", 32'h1, trip_latched);
		tick(12);
		chk("auto clear", 32'h0, trip_latched);
		chk("auto run", 32'h1, motor_run);
		start_cmd <= 1'b0;
		tick(3);
		two_wire <= 1'b0;
		chk("two wire stop", 32'h0, motor_run);
		wr(OFS_POL, 32'h2);
		go();
		heat <= 1'b1;
		tick(4);
		chk("no trip", 32'h0, trip_latched);
		chk("still run", 32'h1, motor_run);
		heat <= 1'b0;
		halt();
		$display("test recovery done");
		reboot(1'b1, 2'h0, 1'b1);
		chk("kept manual", 32'h1, trip_latched);
		reboot(1'b1, 2'h1, 1'b0);
		chk("kept hot", 32'h1, trip_latched);
		reboot(1'b1, 2'h1, 1'b1);
		chk("auto cleared", 32'h0, trip_latched);
		rdc("stat", OFS_STAT, 32'h10);
		$display("test power cycle done");
		final_report();
	end
endmodule
